// ==== pkg/fcd_map.vh ====
// Command codes, status layout and read mode encodings of the flash command decoder
`ifndef FCD_MAP_VH
`define FCD_MAP_VH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define FCD_CMD_READ_ARRAY   8'hFF
`define FCD_CMD_READ_IDENT   8'h90
`define FCD_CMD_READ_QUERY   8'h98
`define FCD_CMD_READ_STATUS  8'h70
`define FCD_CMD_CLEAR_STATUS 8'h50
`define FCD_CMD_PROG_SETUP   8'h40
`define FCD_CMD_PROG_ALT     8'h10
`define FCD_CMD_BUF_PROG     8'hE8
`define FCD_CMD_FACTORY_PROG 8'h80
`define FCD_CMD_ERASE_SETUP  8'h20
`define FCD_CMD_SUSPEND      8'hB0
`define FCD_CMD_CONFIRM      8'hD0
`define FCD_CMD_LOCK_SETUP   8'h60
`define FCD_CMD_LOCK_BLOCK   8'h01
`define FCD_CMD_LOCK_DOWN    8'h2F
`define FCD_CMD_READ_CFG     8'h03
`define FCD_CMD_OTP_PROG     8'hC0

// ------------------------------------------------------------
// Status value
// ------------------------------------------------------------
`define FCD_STATUS_RESET     8'h80
`define FCD_SR_READY         7
`define FCD_SR_ERASE_SUSP    6
`define FCD_SR_ERASE_ERR     5
`define FCD_SR_PROG_ERR      4
`define FCD_SR_PROG_SUSP     2

// ------------------------------------------------------------
// Read modes
// ------------------------------------------------------------
`define FCD_MODE_ARRAY       2'h0
`define FCD_MODE_STATUS      2'h1
`define FCD_MODE_IDENT       2'h2
`define FCD_MODE_QUERY       2'h3

// ------------------------------------------------------------
// Lock control kinds
// ------------------------------------------------------------
`define FCD_LOCK_LOCK        2'h0
`define FCD_LOCK_UNLOCK      2'h1
`define FCD_LOCK_DOWN        2'h2

// ------------------------------------------------------------
// Write buffer
// ------------------------------------------------------------
`define FCD_BUF_WORDS        32
`define FCD_BUF_AW           5

`endif

// ==== verilog/fcd_buffer_mem.v ====
// Write buffer memory with registered read data
`timescale 1ns/10ps
module fcd_buffer_mem #(
  parameter DW = 16,
  parameter AW = 5
) (
  input  wire          ref_clk_in,
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [DW-1:0] rd_data_out
);
  reg [DW-1:0] mem_reg [0:(1<<AW)-1];

  always @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_reg[rd_addr_in];
  end
endmodule // fcd_buffer_mem

// ==== verilog/fcd_command_decoder.v ====
// Command front end of a 16-bit parallel flash: sequence decode, read mode, status, op launch
// Behaviour
// - Every operation starts with a command write decoded here, not stored in the array.
// - Accepted program or erase runs alone until the engine reports done.
// - Active-low reset or suspend command aborts or halts the running operation.
// - 0xFF array read, 0x50 clear errors, 0xB0 suspend, 0xD0 resume.
// - 0x90 selects identifier reads at base plus offset, persisting.
// - 0x98 selects query table reads at base plus offset.
// - 0x70 then a read returns the status value.
// - 0x40 or 0x10 then the data word programs one word.
// - 0xE8, count minus one, up to 32 words, then 0xD0 programs buffer.
// - 0x80 then 0xD0 starts factory programming, then data words stream in through program_word_out, not the buffer.
// - 0x20 then 0xD0 erases the addressed block.
// - 0x60 then 0x01 lock, 0xD0 unlock, 0x2F lock down.
// - 0xC0 then data programs a protection register word.
// - 0xC0 then data at the lock address programs the lock register.
// - 0x60 then 0x03 loads read configuration from address lines.
// - After reset: array read mode, status value 0x80.
// - While an op runs only status read and suspend are accepted, except in factory programming where every write is data.
`timescale 1ns/10ps
`include "fcd_map.vh"
module fcd_command_decoder #(
  parameter AW            = 24,
  parameter DW            = 16,
  parameter [AW-1:0] DEVICE_BASE_ADDR = 24'h000000,
  parameter [AW-1:0] OTP_LOCK_ADDR    = 24'h000080
) (
  input  wire          ref_clk_in,
  input  wire          sys_rst_in,
  input  wire          flash_rst_n_in,
  input  wire          wr_strobe_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  input  wire          rd_strobe_in,
  input  wire [AW-1:0] rd_addr_in,
  input  wire [DW-1:0] array_word_in,
  input  wire [DW-1:0] ident_word_in,
  input  wire [DW-1:0] query_word_in,
  input  wire          op_done_in,
  input  wire          op_err_in,
  input  wire [4:0]    buf_rd_addr_in,
  output wire [DW-1:0] buf_rd_data_out,
  output reg  [DW-1:0] rd_data_out,
  output reg  [AW-1:0] rd_offset_out,
  output reg  [1:0]    read_mode_out,
  output reg  [7:0]    status_value_out,
  output reg  [AW-1:0] target_word_addr_out,
  output reg  [DW-1:0] program_word_out,
  output reg  [4:0]    buf_count_out,
  output reg           prog_start_out,
  output reg           buf_prog_start_out,
  output reg           factory_start_out,
  output reg           factory_word_out,
  output reg           erase_start_out,
  output reg           lock_start_out,
  output reg  [1:0]    lock_kind_out,
  output reg           otp_start_out,
  output reg           otp_is_lock_out,
  output reg           read_cfg_load_out,
  output reg  [15:0]   read_cfg_value_out,
  output reg           suspend_out,
  output reg           resume_out,
  output reg           abort_out,
  output wire          busy_out
);
  // ------------------------------------------------------------
  // Sequence states
  // ------------------------------------------------------------
  localparam [3:0] ST_IDLE     = 4'h0;
  localparam [3:0] ST_PROG     = 4'h1;
  localparam [3:0] ST_ERASE    = 4'h2;
  localparam [3:0] ST_LOCK     = 4'h3;
  localparam [3:0] ST_OTP      = 4'h4;
  localparam [3:0] ST_BUF_CNT  = 4'h5;
  localparam [3:0] ST_BUF_DATA = 4'h6;
  localparam [3:0] ST_BUF_CONF = 4'h7;
  localparam [3:0] ST_FAC_SET  = 4'h8;
  localparam [3:0] ST_FAC_RUN  = 4'h9;

  // ------------------------------------------------------------
  // Reset pin synchroniser
  // ------------------------------------------------------------
  reg       rst_n_meta_reg;
  reg       rst_n_sync_reg;
  always @(posedge ref_clk_in) begin
    rst_n_meta_reg <= flash_rst_n_in;
    rst_n_sync_reg <= rst_n_meta_reg;
  end
  // Pin reset acts like system reset but also aborts any running op
  wire      pin_rst = ~rst_n_sync_reg;
  wire      any_rst = sys_rst_in | pin_rst;

  reg [3:0]    state_reg;
  reg          busy_reg;
  reg          erase_op_reg;
  reg          susp_reg;
  reg [4:0]    buf_idx_reg;
  wire [7:0]   cmd = wr_data_in[7:0];

  assign busy_out = busy_reg;

  // Buffer fills only while collecting buffered words
  wire buf_wr = wr_strobe_in & (state_reg == ST_BUF_DATA);
  fcd_buffer_mem #(.DW(DW), .AW(`FCD_BUF_AW)) u_buf (
    .ref_clk_in (ref_clk_in),
    .wr_en_in   (buf_wr),
    .wr_addr_in (buf_idx_reg),
    .wr_data_in (wr_data_in),
    .rd_addr_in (buf_rd_addr_in),
    .rd_data_out(buf_rd_data_out)
  );

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (any_rst) begin
      rd_data_out   <= 16'h0000;
      rd_offset_out <= {AW{1'b0}};
    end else if (rd_strobe_in) begin
      rd_offset_out <= rd_addr_in - DEVICE_BASE_ADDR;
      case (read_mode_out)
        `FCD_MODE_STATUS: rd_data_out <= {8'h00, status_value_out};
        `FCD_MODE_IDENT:  rd_data_out <= ident_word_in;
        `FCD_MODE_QUERY:  rd_data_out <= query_word_in;
        default:          rd_data_out <= array_word_in;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    prog_start_out     <= 1'b0;
    buf_prog_start_out <= 1'b0;
    factory_start_out  <= 1'b0;
    factory_word_out   <= 1'b0;
    erase_start_out    <= 1'b0;
    lock_start_out     <= 1'b0;
    otp_start_out      <= 1'b0;
    read_cfg_load_out  <= 1'b0;
    suspend_out        <= 1'b0;
    resume_out         <= 1'b0;
    abort_out          <= 1'b0;
    if (any_rst) begin
      abort_out            <= pin_rst & busy_reg;
      state_reg            <= ST_IDLE;
      busy_reg             <= 1'b0;
      erase_op_reg         <= 1'b0;
      susp_reg             <= 1'b0;
      buf_idx_reg          <= 5'h00;
      buf_count_out        <= 5'h00;
      read_mode_out        <= `FCD_MODE_ARRAY;
      status_value_out     <= `FCD_STATUS_RESET;
      target_word_addr_out <= {AW{1'b0}};
      program_word_out     <= 16'h0000;
      lock_kind_out        <= `FCD_LOCK_LOCK;
      otp_is_lock_out      <= 1'b0;
      read_cfg_value_out   <= 16'h0000;
    end else begin
      status_value_out[`FCD_SR_READY] <= ~busy_reg | susp_reg;
      // Engine completion; error set placed after clear below so set wins
      if (op_done_in & busy_reg & ~susp_reg) begin
        busy_reg  <= 1'b0;
        state_reg <= ST_IDLE;
      end
      if (wr_strobe_in) begin
        if (busy_reg & ~susp_reg & (state_reg != ST_FAC_RUN)) begin
          // Running op: only status read and suspend get through
          if (cmd == `FCD_CMD_READ_STATUS) begin
            read_mode_out <= `FCD_MODE_STATUS;
          // Suspend racing completion is dropped, else suspend sticks with no op
          end else if ((cmd == `FCD_CMD_SUSPEND) & ~op_done_in) begin
            suspend_out <= 1'b1;
            susp_reg    <= 1'b1;
            if (erase_op_reg) begin
              status_value_out[`FCD_SR_ERASE_SUSP] <= 1'b1;
            end else begin
              status_value_out[`FCD_SR_PROG_SUSP] <= 1'b1;
            end
          end
        end else begin
          case (state_reg)
            ST_IDLE: begin
              target_word_addr_out <= wr_addr_in;
              case (cmd)
                `FCD_CMD_READ_ARRAY:  read_mode_out <= `FCD_MODE_ARRAY;
                `FCD_CMD_READ_IDENT:  read_mode_out <= `FCD_MODE_IDENT;
                `FCD_CMD_READ_QUERY:  read_mode_out <= `FCD_MODE_QUERY;
                `FCD_CMD_READ_STATUS: read_mode_out <= `FCD_MODE_STATUS;
                `FCD_CMD_CLEAR_STATUS: begin
                  status_value_out[`FCD_SR_ERASE_ERR] <= 1'b0;
                  status_value_out[`FCD_SR_PROG_ERR]  <= 1'b0;
                end
                `FCD_CMD_CONFIRM: begin
                  if (susp_reg) begin
                    resume_out <= 1'b1;
                    susp_reg   <= 1'b0;
                    read_mode_out <= `FCD_MODE_STATUS;
                    status_value_out[`FCD_SR_ERASE_SUSP] <= 1'b0;
                    status_value_out[`FCD_SR_PROG_SUSP]  <= 1'b0;
                  end
                end
                `FCD_CMD_PROG_SETUP, `FCD_CMD_PROG_ALT: begin
                  if (!susp_reg) state_reg <= ST_PROG;
                end
                `FCD_CMD_BUF_PROG: begin
                  if (!susp_reg) state_reg <= ST_BUF_CNT;
                end
                `FCD_CMD_FACTORY_PROG: begin
                  if (!susp_reg) state_reg <= ST_FAC_SET;
                end
                `FCD_CMD_ERASE_SETUP: begin
                  if (!susp_reg) state_reg <= ST_ERASE;
                end
                `FCD_CMD_LOCK_SETUP: begin
                  if (!susp_reg) state_reg <= ST_LOCK;
                end
                `FCD_CMD_OTP_PROG: begin
                  if (!susp_reg) state_reg <= ST_OTP;
                end
                default: ;
              endcase
            end
            ST_PROG: begin
              target_word_addr_out <= wr_addr_in;
              program_word_out     <= wr_data_in;
              prog_start_out       <= 1'b1;
              busy_reg             <= 1'b1;
              erase_op_reg         <= 1'b0;
              read_mode_out        <= `FCD_MODE_STATUS;
              state_reg            <= ST_IDLE;
            end
            ST_ERASE: begin
              read_mode_out <= `FCD_MODE_STATUS;
              state_reg     <= ST_IDLE;
              if (cmd == `FCD_CMD_CONFIRM) begin
                erase_start_out <= 1'b1;
                busy_reg        <= 1'b1;
                erase_op_reg    <= 1'b1;
              end else begin
                status_value_out[`FCD_SR_ERASE_ERR] <= 1'b1;
                status_value_out[`FCD_SR_PROG_ERR]  <= 1'b1;
              end
            end
            ST_LOCK: begin
              state_reg <= ST_IDLE;
              case (cmd)
                `FCD_CMD_LOCK_BLOCK: begin
                  lock_kind_out  <= `FCD_LOCK_LOCK;
                  lock_start_out <= 1'b1;
                end
                `FCD_CMD_CONFIRM: begin
                  lock_kind_out  <= `FCD_LOCK_UNLOCK;
                  lock_start_out <= 1'b1;
                end
                `FCD_CMD_LOCK_DOWN: begin
                  lock_kind_out  <= `FCD_LOCK_DOWN;
                  lock_start_out <= 1'b1;
                end
                `FCD_CMD_READ_CFG: begin
                  read_cfg_value_out <= wr_addr_in[15:0];
                  read_cfg_load_out  <= 1'b1;
                end
                default: begin
                  read_mode_out <= `FCD_MODE_STATUS;
                  status_value_out[`FCD_SR_ERASE_ERR] <= 1'b1;
                  status_value_out[`FCD_SR_PROG_ERR]  <= 1'b1;
                end
              endcase
            end
            ST_OTP: begin
              target_word_addr_out <= wr_addr_in;
              program_word_out     <= wr_data_in;
              otp_is_lock_out      <= (wr_addr_in == OTP_LOCK_ADDR);
              otp_start_out        <= 1'b1;
              busy_reg             <= 1'b1;
              erase_op_reg         <= 1'b0;
              read_mode_out        <= `FCD_MODE_STATUS;
              state_reg            <= ST_IDLE;
            end
            ST_BUF_CNT: begin
              buf_idx_reg <= 5'h00;
              read_mode_out <= `FCD_MODE_STATUS;
              // Count word above the buffer size minus one cannot be honoured
              if (wr_data_in > (`FCD_BUF_WORDS - 1)) begin
                status_value_out[`FCD_SR_ERASE_ERR] <= 1'b1;
                status_value_out[`FCD_SR_PROG_ERR]  <= 1'b1;
                state_reg <= ST_IDLE;
              end else begin
                buf_count_out <= wr_data_in[4:0];
                state_reg     <= ST_BUF_DATA;
              end
            end
            ST_BUF_DATA: begin
              buf_idx_reg <= buf_idx_reg + 5'h01;
              if (buf_idx_reg == buf_count_out) begin
                state_reg <= ST_BUF_CONF;
              end
            end
            ST_BUF_CONF: begin
              state_reg <= ST_IDLE;
              if (cmd == `FCD_CMD_CONFIRM) begin
                buf_prog_start_out <= 1'b1;
                busy_reg           <= 1'b1;
                erase_op_reg       <= 1'b0;
              end else begin
                status_value_out[`FCD_SR_ERASE_ERR] <= 1'b1;
                status_value_out[`FCD_SR_PROG_ERR]  <= 1'b1;
              end
            end
            ST_FAC_SET: begin
              read_mode_out <= `FCD_MODE_STATUS;
              if (cmd == `FCD_CMD_CONFIRM) begin
                factory_start_out <= 1'b1;
                busy_reg          <= 1'b1;
                erase_op_reg      <= 1'b0;
                state_reg         <= ST_FAC_RUN;
              end else begin
                status_value_out[`FCD_SR_ERASE_ERR] <= 1'b1;
                status_value_out[`FCD_SR_PROG_ERR]  <= 1'b1;
                state_reg <= ST_IDLE;
              end
            end
            ST_FAC_RUN: begin
              // Every write is a data word; engine ends the run with done
              program_word_out <= wr_data_in;
              factory_word_out <= 1'b1;
            end
            default: state_reg <= ST_IDLE;
          endcase
        end
      end
      if (op_err_in & busy_reg) begin
        if (erase_op_reg) begin
          status_value_out[`FCD_SR_ERASE_ERR] <= 1'b1;
        end else begin
          status_value_out[`FCD_SR_PROG_ERR] <= 1'b1;
        end
      end
    end
  end
endmodule // fcd_command_decoder

// ==== tb/fcd_asserts.sv ====
// Concurrent checks on the command decoder ports
`timescale 1ns/10ps
module fcd_asserts #(parameter AW = 24, parameter DW = 16) (
  input wire          ref_clk_in,
  input wire          sys_rst_in,
  input wire          flash_rst_n_in,
  input wire          wr_strobe_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [DW-1:0] wr_data_in,
  input wire          op_done_in,
  input wire [1:0]    read_mode_out,
  input wire [7:0]    status_value_out,
  input wire [AW-1:0] target_word_addr_out,
  input wire [DW-1:0] program_word_out,
  input wire          prog_start_out,
  input wire          erase_start_out,
  input wire          factory_start_out,
  input wire          suspend_out,
  input wire          abort_out,
  input wire          busy_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire [7:0] code    = wr_data_in[7:0];
  wire       idle_wr = wr_strobe_in && !busy_out;
  // Factory run turns every write into data, suspend code included
  reg        fac_run_reg = 1'b0;
  always @(posedge ref_clk_in) begin
    if (sys_rst_in || !busy_out) fac_run_reg <= 1'b0;
    else if (factory_start_out) fac_run_reg <= 1'b1;
  end
  // A write right after another may be a data word, not a setup code
  sequence s_prog_setup; idle_wr && !$past(wr_strobe_in) && (code == 8'h40 || code == 8'h10); endsequence
  sequence s_erase_setup; idle_wr && !$past(wr_strobe_in) && code == 8'h20; endsequence
  a_reset_state: assert property ($fell(sys_rst_in) |-> status_value_out == 8'h80 && read_mode_out == 2'h0)
    else $error("reset state wrong");
  a_word_prog: assert property (s_prog_setup ##1 wr_strobe_in |=> prog_start_out && busy_out
    && target_word_addr_out == $past(wr_addr_in) && program_word_out == $past(wr_data_in) && read_mode_out == 2'h1)
    else $error("word program launch wrong");
  a_erase_go: assert property (s_erase_setup ##1 (wr_strobe_in && code == 8'hD0) |=> erase_start_out)
    else $error("erase not launched");
  a_bad_confirm: assert property (s_erase_setup ##1 (wr_strobe_in && code != 8'hD0)
    |=> !erase_start_out && status_value_out[5:4] == 2'b11) else $error("bad confirm accepted");
  a_busy_refuse: assert property (busy_out && !status_value_out[7] && !suspend_out && wr_strobe_in && code == 8'hFF
    |=> read_mode_out == $past(read_mode_out)) else $error("command taken while busy");
  a_read_status: assert property (idle_wr && code == 8'h70 |=> read_mode_out == 2'h1)
    else $error("status mode not entered");
  a_suspend_op: assert property (busy_out && !status_value_out[7] && !suspend_out && !op_done_in
    && !fac_run_reg && !factory_start_out && wr_strobe_in && code == 8'hB0 |=> suspend_out)
    else $error("suspend not issued");
  a_done_idle: assert property (busy_out && op_done_in |=> !busy_out)
    else $error("busy after done");
  a_pin_abort: assert property (busy_out && $fell(flash_rst_n_in) |-> ##[1:4] abort_out)
    else $error("pin reset did not abort");
  a_pulse_one: assert property (prog_start_out |=> !prog_start_out)
    else $error("start pulse too long");
endmodule // fcd_asserts

bind fcd_command_decoder fcd_asserts #(.AW(AW), .DW(DW)) u_fcd_asserts (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .flash_rst_n_in(flash_rst_n_in),
  .wr_strobe_in(wr_strobe_in), .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in), .op_done_in(op_done_in),
  .read_mode_out(read_mode_out), .status_value_out(status_value_out),
  .target_word_addr_out(target_word_addr_out), .program_word_out(program_word_out),
  .prog_start_out(prog_start_out), .erase_start_out(erase_start_out), .factory_start_out(factory_start_out),
  .suspend_out(suspend_out),
  .abort_out(abort_out), .busy_out(busy_out));

// ==== tb/fcd_engine_model.sv ====
// Behavioural program and erase engine answering the decoder's launch pulses
`timescale 1ns/10ps
module fcd_engine_model (
  input  wire        ref_clk_in,
  input  wire        sys_rst_in,
  input  wire [7:0]  dly_in,
  input  wire        start_in,
  input  wire        buf_start_in,
  input  wire [4:0]  buf_count_in,
  input  wire        suspend_in,
  input  wire        resume_in,
  input  wire        abort_in,
  input  wire [15:0] buf_rd_data_in,
  output reg         op_done_out,
  output reg         op_err_out,
  output reg  [4:0]  buf_rd_addr_out,
  output reg  [15:0] buf_xor_out
);
  integer left;
  integer idx;
  reg     held;
  always @(posedge ref_clk_in) begin
    op_done_out <= 1'b0;
    op_err_out  <= 1'b0;
    if (sys_rst_in || abort_in) begin
      left <= 0; held <= 1'b0; idx <= 99; buf_rd_addr_out <= 5'h00; buf_xor_out <= 16'h0000;
    end else if (start_in || buf_start_in) begin
      left <= dly_in; held <= 1'b0; buf_rd_addr_out <= 5'h00; buf_xor_out <= 16'h0000;
      idx <= buf_start_in ? 0 : 99;
    end else begin
      if (suspend_in) held <= 1'b1;
      if (resume_in) held <= 1'b0;
      // Registered buffer data lags the address by one cycle
      if (idx <= buf_count_in + 1) begin
        idx <= idx + 1;
        buf_rd_addr_out <= idx + 1;
        if (idx >= 1) buf_xor_out <= buf_xor_out ^ buf_rd_data_in;
      end
      if (!held && left > 0) begin
        left <= left - 1;
        if (left == 1) begin
          op_done_out <= 1'b1;
          // Odd delay marks a failing operation
          op_err_out  <= dly_in[0];
        end
      end
    end
  end
endmodule // fcd_engine_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the flash command decoder
`timescale 1ns/10ps
module tb_top;
  reg ref_clk = 1'b0, sys_rst = 1'b1, pin_n = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  reg [23:0] wr_addr = 24'h0, rd_addr = 24'h0, a;
  reg [15:0] wr_data = 16'h0, arr_w = 16'h0, id_w = 16'h0, q_w = 16'h0, d, xr;
  reg [7:0]  dly = 8'h04;
  wire [15:0] buf_q, rd_q, rc_val, bxor, pw;
  wire [23:0] rd_off, tgt;
  wire [7:0]  sr;
  wire [4:0]  bcnt, braddr;
  wire [1:0]  mode, lkind;
  wire p_st, b_st, f_st, f_w, e_st, l_st, o_st, o_lk, rc_ld, susp, resm, abrt, busy, done, err;
  integer n_fail = 0, checks_done = 0, cyc = 0, aborts = 0, k, i, n;
  initial forever #2.5 ref_clk = ~ref_clk;
  fcd_command_decoder u_fcd_command_decoder (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .flash_rst_n_in(pin_n),
    .wr_strobe_in(wr_stb), .wr_addr_in(wr_addr), .wr_data_in(wr_data), .rd_strobe_in(rd_stb), .rd_addr_in(rd_addr),
    .array_word_in(arr_w), .ident_word_in(id_w), .query_word_in(q_w), .op_done_in(done), .op_err_in(err),
    .buf_rd_addr_in(braddr), .buf_rd_data_out(buf_q), .rd_data_out(rd_q), .rd_offset_out(rd_off),
    .read_mode_out(mode), .status_value_out(sr), .target_word_addr_out(tgt), .program_word_out(pw),
    .buf_count_out(bcnt), .prog_start_out(p_st), .buf_prog_start_out(b_st), .factory_start_out(f_st),
    .factory_word_out(f_w), .erase_start_out(e_st), .lock_start_out(l_st), .lock_kind_out(lkind),
    .otp_start_out(o_st), .otp_is_lock_out(o_lk), .read_cfg_load_out(rc_ld), .read_cfg_value_out(rc_val),
    .suspend_out(susp), .resume_out(resm), .abort_out(abrt), .busy_out(busy));
  fcd_engine_model u_fcd_engine_model (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .dly_in(dly),
    .start_in(p_st | e_st | o_st | f_st), .buf_start_in(b_st), .buf_count_in(bcnt), .suspend_in(susp),
    .resume_in(resm), .abort_in(abrt), .buf_rd_data_in(buf_q), .op_done_out(done), .op_err_out(err),
    .buf_rd_addr_out(braddr), .buf_xor_out(bxor));
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (abrt === 1'b1) aborts = aborts + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  task chk(input [31:0] seen, input [31:0] want);
    begin
      checks_done = checks_done + 1;
      if (seen !== want) begin
        n_fail = n_fail + 1;
        $display("ERROR %0t: saw %0h expected %0h", $time, seen, want);
      end
    end
  endtask
  task wr(input [23:0] wa, input [15:0] wd);
    begin @(posedge ref_clk); #1; wr_stb = 1'b1; wr_addr = wa; wr_data = wd; end
  endtask
  task gap;
    begin @(posedge ref_clk); #1; wr_stb = 1'b0; rd_stb = 1'b0; end
  endtask
  task cmd(input [15:0] wd);
    begin wr(24'h0, wd); gap; end
  endtask
  task rd(input [23:0] ra);
    begin @(posedge ref_clk); #1; rd_stb = 1'b1; rd_addr = ra; gap; end
  endtask
  task wait_done;
    begin
      for (i = 0; i < 300 && busy !== 1'b0; i = i + 1) gap;
      gap;
      chk(busy, 0);
      chk(sr, 8'h80);
    end
  endtask
  task final_report;
    begin
      $display("counts: %0d checks, %0d mismatches", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    k = $urandom(32'h388C);
    arr_w = $urandom; id_w = $urandom; q_w = $urandom;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    chk(sr, 8'h80); chk(mode, 0);
    cmd(16'h0070); rd(24'h0); chk(rd_q, 16'h0080);
    $display("test reset done");
    // ------------------------------------------------------------
    // Word program with both setup codes, then erase with suspend
    // ------------------------------------------------------------
    for (k = 0; k < 2; k = k + 1) begin
      a = $urandom; d = $urandom | 16'h0005;
      wr(a, k ? 16'h0010 : 16'h0040); wr(a, d); gap;
      chk(p_st, 1); chk(tgt, a); chk(pw, d); chk(mode, 1);
      wait_done;
    end
    dly = 8'd40; wr(a, 16'h0020); wr(a, 16'h00D0); gap; chk(e_st, 1);
    cmd(16'h00FF); chk(mode, 1);
    cmd(16'h00B0); chk(susp, 1); gap; chk(sr, 8'hC0);
    cmd(16'h00D0); chk(resm, 1); chk(busy, 1); wait_done;
    wr(a, 16'h0020); wr(a, 16'h0055); gap; chk(e_st, 0); chk(sr, 8'hB0);
    cmd(16'h0050); chk(sr, 8'h80);
    wr(a, 16'h00E8); wr(a, 16'h0020); gap; chk(sr, 8'hB0); cmd(16'h0050);
    $display("test program and erase done");
    for (k = 0; k < 3; k = k + 1) begin
      dly = 8'd4; wr(a, 16'h0060); wr(a, k == 0 ? 16'h0001 : k == 1 ? 16'h00D0 : 16'h002F); gap;
      chk(l_st, 1); chk(lkind, k); wait_done;
    end
    a = $urandom; wr(a, 16'h0060); wr(a, 16'h0003); gap; chk(rc_ld, 1); chk(rc_val, a[15:0]);
    for (k = 0; k < 2; k = k + 1) begin
      a = k ? 24'h000080 : 24'h000100; wr(a, 16'h00C0); wr(a, $urandom); gap;
      chk(o_st, 1); chk(o_lk, k); wait_done;
    end
    for (k = 0; k < 2; k = k + 1) begin
      n = k ? 32 : 1 + $urandom % 31; a = $urandom; xr = 16'h0000; dly = 8'd60;
      wr(a, 16'h00E8); wr(a, n - 1);
      for (i = 0; i < n; i = i + 1) begin d = $urandom; xr = xr ^ d; wr(a + i, d); end
      wr(a, 16'h00D0); gap; chk(b_st, 1); chk(bcnt, n - 1);
      wait_done; chk(bxor, xr);
    end
    dly = 8'd40; wr(a, 16'h0080); wr(a, 16'h00D0); gap; chk(f_st, 1);
    wr(a, $urandom); gap; chk(f_w, 1); wait_done;
    $display("test lock, config and buffers done");
    cmd(16'h00FF); chk(mode, 0); rd(a); chk(rd_q, arr_w);
    cmd(16'h0090); a = $urandom % 64;
    for (k = 0; k < 2; k = k + 1) begin rd(a + k); chk(rd_q, id_w); chk(rd_off, a + k); end
    cmd(16'h0098); rd(a); chk(mode, 3); chk(rd_q, q_w);
    dly = 8'd5; wr(a, 16'h0040); wr(a, 16'h0001); gap;
    repeat (12) gap; chk(busy, 0); chk(sr, 8'h90); cmd(16'h0050); chk(sr, 8'h80);
    $display("test read modes done");
    dly = 8'd200; wr(a, 16'h0040); wr(a, 16'h1235); gap;
    pin_n = 1'b0; repeat (5) gap; chk(aborts, 1);
    pin_n = 1'b1; repeat (5) gap; chk(busy, 0); chk(mode, 0); chk(sr, 8'h80);
    $display("test pin reset done");
    final_report;
  end
endmodule // tb_top
